/* bench/ee_model.sv */
// eeprom model: variable read latency, injected bit flips, stores program writes
`timescale 1ns/1ps
module ee_model
  import sensor_flags_pkg::*;
(
  input wire logic clk_sys,
  input wire logic ee_rd_req,
  input wire logic ee_wr_req,
  input wire logic [4:0] ee_addr,
  input wire logic [EE_WORD_W-1:0] ee_wdata,
  input wire logic [4:0] bad_addr,
  input wire logic [EE_WORD_W-1:0] flip,
  input wire logic [3:0] lat,
  output logic [EE_WORD_W-1:0] ee_rdata,
  output logic ee_rvalid
);
  logic [EE_WORD_W-1:0] mem [0:16];
  logic [4:0] addr;
  int wait_n;
  // ==========================================================
  // blank array, all-zero codewords are valid for any linear code
  initial
  begin
    foreach (mem[i])
      mem[i] = '0;
    ee_rvalid = 1'b0;
    ee_rdata = '0;
    wait_n = 0;
  end
  // stale read data toggles so the design cannot lean on it
  always @(posedge clk_sys)
  begin
    ee_rvalid <= 1'b0;
    if (ee_wr_req)
      mem[ee_addr] <= ee_wdata;
    if (ee_rd_req)
    begin
      addr <= ee_addr;
      wait_n <= lat;
    end
    else if (wait_n != 0)
    begin
      wait_n <= wait_n - 1;
      if (wait_n == 1)
      begin
        ee_rvalid <= 1'b1;
        ee_rdata <= mem[addr] ^ ((addr == bad_addr) ? flip : '0);
      end
    end
    else
      ee_rdata <= ~ee_rdata;
  end
endmodule

/* bench/sensor_flags_asserts.sv */
// port-level assertion checker for the sensor_condition_flags flag block
`timescale 1ns/1ps
module sensor_flags_asserts
  import sensor_flags_pkg::*;
#(
  parameter int ADDR_W = 4
)
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire meas_evt_t meas_evt,
  input wire logic overtemp_pin,
  input wire logic echo_above_thr,
  input wire logic [7:0] sensor_condition_flags,
  input wire logic line_echo,
  input wire logic power_down,
  input wire logic tx_stop,
  input wire logic osc_tick,
  input wire logic ee_rd_req,
  input wire logic ee_wr_req,
  input wire logic [ADDR_W:0] ee_addr
);
  logic [ADDR_W:0] last_rd;
  logic indirect;
  logic open_meas;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // ==========================================================
  // helpers: last read address, receive-only measurement, measurement open
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      last_rd <= '0;
      indirect <= 1'b0;
      open_meas <= 1'b0;
    end
    else
    begin
      if (ee_rd_req)
        last_rd <= ee_addr;
      // measurement window, echo is only reported inside it
      if (meas_evt.start)
        open_meas <= 1'b1;
      else if (meas_evt.done)
        open_meas <= 1'b0;
      if (meas_evt.start)
        indirect <= !meas_evt.direct;
    end
  end
  // ==========================================================
  // properties
  chk_tick_period: assert property (osc_tick |-> ##25 osc_tick)
    else $error("oscillator tick period wrong");
  chk_por_flags: assert property ($rose(arst_n) |-> (sensor_condition_flags & 8'h84) == 8'h84)
    else $error("power-on flags missing");
  chk_echo_out: assert property (open_meas && echo_above_thr |=> line_echo || power_down)
    else $error("echo not signalled");
  chk_quiet_down: assert property (power_down && $past(power_down) |-> !line_echo)
    else $error("line active in power-down");
  chk_hot_flag: assert property ($rose(overtemp_pin) |-> ##[2:6] (power_down && sensor_condition_flags[6]))
    else $error("overtemp not flagged");
  chk_cool_back: assert property ($fell(overtemp_pin) |-> ##[2:6] !power_down)
    else $error("power-down not released");
  chk_ov_stop: assert property ($rose(meas_evt.ov) && meas_evt.tx_active |-> ##[1:2] tx_stop)
    else $error("burst not stopped on overvoltage");
  chk_rd_pulse: assert property (ee_rd_req |=> !ee_rd_req)
    else $error("read request longer than one cycle");
  chk_rd_order: assert property (ee_rd_req && ee_addr != '0 |-> ee_addr == last_rd + 1'b1)
    else $error("refresh address out of order");
  chk_wr_range: assert property (ee_wr_req |-> ee_addr <= (1 << ADDR_W))
    else $error("program address beyond crc word");
  chk_indirect_keep: assert property (indirect && !meas_evt.start |=> $stable(sensor_condition_flags[5:1]))
    else $error("indirect measurement changed direct flags");
endmodule

bind sensor_condition_flags_flags sensor_flags_asserts #(.ADDR_W(ADDR_W)) u_chk (
  .clk_sys(clk_sys), .arst_n(arst_n), .meas_evt(meas_evt), .overtemp_pin(overtemp_pin),
  .echo_above_thr(echo_above_thr), .sensor_condition_flags(sensor_condition_flags),
  .line_echo(line_echo), .power_down(power_down), .tx_stop(tx_stop), .osc_tick(osc_tick),
  .ee_rd_req(ee_rd_req), .ee_wr_req(ee_wr_req), .ee_addr(ee_addr));

/* bench/tb_sensor_condition_flags_flags.sv */
// self-checking testbench for the sensor_condition_flags flag block
`timescale 1ns/1ps
module tb_sensor_condition_flags_flags
  import sensor_flags_pkg::*;
;
  logic clk_sys, arst_n, clk_en, overtemp_pin, echo_above_thr, cfg_read_strobe;
  logic refresh_cmd, program_cmd, ee_rvalid, obs;
  logic line_echo, power_down, tx_stop, osc_tick, ee_rd_req, ee_wr_req, refresh_busy;
  meas_evt_t meas_evt;
  ring_cfg_t ring_cfg;
  logic [7:0] cfg_read_item, flags, cfg_rd_data, v;
  logic [EE_WORD_W-1:0] ee_rdata, ee_wdata, flip;
  logic [3:0] cfg_rd_addr, lat;
  logic [15:0] cfg_backed;
  logic [4:0] ee_addr, bad_addr;
  logic [9:0] c, t, p;
  logic [31:0] r;
  int k, mismatches, compares;
  logic [7:0] exp_q[$];

  sensor_condition_flags_flags u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en),
    .meas_evt(meas_evt), .ring_cfg(ring_cfg), .overtemp_pin(overtemp_pin),
    .echo_above_thr(echo_above_thr), .cfg_read_strobe(cfg_read_strobe),
    .cfg_read_item(cfg_read_item), .refresh_cmd(refresh_cmd), .program_cmd(program_cmd),
    .ee_rdata(ee_rdata), .ee_rvalid(ee_rvalid), .cfg_rd_addr(cfg_rd_addr),
    .cfg_backed(cfg_backed), .sensor_condition_flags(flags), .cfg_rd_data(cfg_rd_data),
    .line_echo(line_echo), .power_down(power_down), .tx_stop(tx_stop), .osc_tick(osc_tick),
    .ee_rd_req(ee_rd_req), .ee_wr_req(ee_wr_req), .ee_addr(ee_addr), .ee_wdata(ee_wdata),
    .refresh_busy(refresh_busy));
  ee_model u_ee (.clk_sys(clk_sys), .ee_rd_req(ee_rd_req), .ee_wr_req(ee_wr_req),
    .ee_addr(ee_addr), .ee_wdata(ee_wdata), .bad_addr(bad_addr), .flip(flip), .lat(lat),
    .ee_rdata(ee_rdata), .ee_rvalid(ee_rvalid));

  // ==========================================================
  // clock, watchdog, result monitor
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial
  begin
    #200000;
    mismatches++;
    wrap_up();
  end
  always @(posedge clk_sys)
    if (obs && exp_q.size() > 0)
      check(flags, exp_q.pop_front());

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t flags %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================================
  // drivers, all on the falling edge
  task automatic tick(input int n);
    repeat (n)
    begin
      @(negedge clk_sys);
      echo_above_thr = 1'($urandom);
      cfg_rd_addr = 4'($urandom);
    end
  endtask
  task automatic note(input logic [7:0] e);
    v = e;
    exp_q.push_back(e);
    obs = 1'b1;
    tick(1);
    obs = 1'b0;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    tick(2);
    while (refresh_busy !== 1'b0 && n < 3000)
    begin
      tick(1);
      n++;
    end
    if (n >= 3000)
      mismatches++;
  endtask
  task automatic cmd(input bit prog);
    program_cmd = prog;
    refresh_cmd = !prog;
    lat = 4'($urandom_range(1, 6));
    tick(1);
    program_cmd = 1'b0;
    refresh_cmd = 1'b0;
    wait_idle();
  endtask
  // one measurement: start, tx burst, ringing end, done
  task automatic measure(input bit dir, input bit uv, input bit ov, input bit dec, input bit nz);
    meas_evt = '0;
    meas_evt.start = 1'b1;
    meas_evt.direct = dir;
    tick(1);
    meas_evt.start = 1'b0;
    meas_evt.tx_active = dir;
    tick(2);
    meas_evt.uv = uv;
    meas_evt.ov = ov;
    meas_evt.noise_over = nz;
    tick(2);
    meas_evt = '0;
    meas_evt.direct = dir;
    meas_evt.tx_end = dir;
    tick(1);
    meas_evt.tx_end = 1'b0;
    meas_evt.ring_decayed = dec;
    tick(1);
    meas_evt.ring_decayed = 1'b0;
    meas_evt.done = 1'b1;
    tick(1);
    meas_evt = '0;
    tick(3);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    {arst_n, obs, overtemp_pin, echo_above_thr, cfg_read_strobe, refresh_cmd, program_cmd} = '0;
    {meas_evt, ring_cfg, cfg_read_item, cfg_rd_addr, bad_addr, flip} = '0;
    {mismatches, compares} = '0;
    clk_en = 1'b1;
    lat = 4'h2;
    cfg_backed = 16'hFFFF;
    r = $urandom(69379);
    tick(16);
    arst_n = 1'b1;
    note(8'h84);
    wait_idle();
    cfg_backed = 16'($urandom);
    cmd(1'b1);
    cmd(1'b0);
    cfg_read_item = CFG_ITEM_STATUS;
    cfg_read_strobe = 1'b1;
    tick(1);
    cfg_read_strobe = 1'b0;
    tick(2);
    note(8'h04);
    $display("done: boot, program, refresh, read clear");
    repeat (8)
    begin
      c = 10'($urandom_range(100, 600));
      t = 10'($urandom_range(0, 60));
      k = $urandom_range(0, 2);
      p = (k == 0) ? c : (k == 1) ? c + t + 10'd2 : c - t - 10'd2;
      ring_cfg = '{p, c, t, 8'hFF, 8'h01};
      r = $urandom;
      measure(1'b1, r[0], r[1], r[2], r[3]);
      note({3'b000, r[2], p > c, k != 0, r[0] | r[1], r[3]});
    end
    $display("done: direct measurements");
    measure(1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
    note({v[7:1], 1'b1});
    overtemp_pin = 1'b1;
    tick(10);
    note(v | 8'h40);
    overtemp_pin = 1'b0;
    tick(10);
    note(v);
    measure(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    note({2'b00, v[5:1], 1'b0});
    $display("done: indirect and overtemp");
    bad_addr = 5'd3;
    flip = 13'h0010;
    cmd(1'b0);
    note(v);
    flip = 13'h0011;
    cmd(1'b0);
    note(v | 8'h80);
    flip = '0;
    cmd(1'b0);
    note(v & 8'h7F);
    $display("done: eeprom error injection");
    wrap_up();
  end
endmodule

/* core/sensor_condition_flags_flags.sv */
// sensor_condition_flags flags with eeprom refresh ecc and crc checking
`timescale 1ns/1ps
// ==========================================================
module sensor_condition_flags_flags
  import sensor_flags_pkg::*;
#(
  parameter int CFG_WORDS = 16,
  parameter int ADDR_W = 4
)
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire meas_evt_t meas_evt,
  input wire ring_cfg_t ring_cfg,
  input wire logic overtemp_pin,
  input wire logic echo_above_thr,
  input wire logic cfg_read_strobe,
  input wire logic [7:0] cfg_read_item,
  input wire logic refresh_cmd,
  input wire logic program_cmd,
  input wire logic [EE_WORD_W-1:0] ee_rdata,
  input wire logic ee_rvalid,
  input wire logic [ADDR_W-1:0] cfg_rd_addr,
  input wire logic [CFG_WORDS-1:0] cfg_backed,
  output logic [7:0] sensor_condition_flags,
  output logic [7:0] cfg_rd_data,
  output logic line_echo,
  output logic power_down,
  output logic tx_stop,
  output logic osc_tick,
  output logic ee_rd_req,
  output logic ee_wr_req,
  output logic [ADDR_W:0] ee_addr,
  output logic [EE_WORD_W-1:0] ee_wdata,
  output logic refresh_busy
);

  // ==========================================================
  // helpers
  function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic [7:0] d);
    logic [7:0] c;
    c = crc;
    for (int i = 0; i < 8; i++)
    begin
      if (c[7] ^ d[i])
        c = {c[6:0], 1'b0} ^ CRC_POLY;
      else
        c = {c[6:0], 1'b0};
    end
    return c;
  endfunction

  // hamming positions 1..12 plus overall parity bit
  function automatic logic [EE_WORD_W-1:0] ecc_encode(input logic [7:0] d);
    logic [12:1] w;
    logic p;
    w = '0;
    {w[12], w[11], w[10], w[9], w[7], w[6], w[5], w[3]} = d;
    w[1] = w[3] ^ w[5] ^ w[7] ^ w[9] ^ w[11];
    w[2] = w[3] ^ w[6] ^ w[7] ^ w[10] ^ w[11];
    w[4] = w[5] ^ w[6] ^ w[7] ^ w[12];
    w[8] = w[9] ^ w[10] ^ w[11] ^ w[12];
    p = ^w;
    return {p, w};
  endfunction

  // returns {double_err, corrected data}
  function automatic logic [8:0] ecc_decode(input logic [EE_WORD_W-1:0] cw);
    logic [12:1] w;
    logic [3:0] syn;
    logic par;
    logic dbl;
    w = cw[11:0];
    syn[0] = w[1] ^ w[3] ^ w[5] ^ w[7] ^ w[9] ^ w[11];
    syn[1] = w[2] ^ w[3] ^ w[6] ^ w[7] ^ w[10] ^ w[11];
    syn[2] = w[4] ^ w[5] ^ w[6] ^ w[7] ^ w[12];
    syn[3] = w[8] ^ w[9] ^ w[10] ^ w[11] ^ w[12];
    par = ^cw;
    dbl = 1'b0;
    if (syn != 4'h0 && !par)
      dbl = 1'b1;
    else if (syn != 4'h0 && syn <= 4'hC)
      w[syn] = ~w[syn];
    return {dbl, w[12], w[11], w[10], w[9], w[7], w[6], w[5], w[3]};
  endfunction

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0] flags;
    logic por_flag;
    logic dbl_err;
    logic crc_err;
    logic [4:0] div_cnt;
    logic tick;
    logic in_meas;
    logic direct;
    logic ov_pre;
    logic tx_stop;
    logic ring_on;
    logic [16:0] tout_cnt;
    logic [15:0] mon_cnt;
    logic tout_run;
    logic decayed_early;
    logic [2:0] ot_sync;
    logic ot_state;
    logic echo;
    logic pd;
    ee_state_t st;
    logic [ADDR_W:0] addr;
    logic [7:0] crc;
    logic dbl_acc;
    logic [7:0] rd_data;
    logic boot;
  } state_t;

  state_t s_reg;
  state_t s_next;
  logic [7:0] cfg_mem [CFG_WORDS];
  logic [8:0] dec;
  logic last_word;
  logic [4:0] ov_code;
  logic flag_read;

  assign dec = ecc_decode(ee_rdata);
  assign last_word = (s_reg.addr == ADDR_W'(CFG_WORDS - 1));
  assign flag_read = cfg_read_strobe && (cfg_read_item == CFG_ITEM_STATUS);

  // ==========================================================
  // next state
  always_comb
  begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (s_reg.div_cnt == 5'(OSC_DIV - 1))
    begin
      s_next.div_cnt = '0;
      s_next.tick = 1'b1;
    end
    else
      s_next.div_cnt = s_reg.div_cnt + 5'h01;

    // thermal input, change accepted when stages two and three agree
    s_next.ot_sync = {s_reg.ot_sync[1:0], overtemp_pin};
    if (s_reg.ot_sync[2] == s_reg.ot_sync[1])
      s_next.ot_state = s_reg.ot_sync[2];
    s_next.pd = s_reg.ot_state;
    // echo level to line driver, silent in power-down
    s_next.echo = echo_above_thr && s_reg.in_meas && !s_reg.ot_state;

    // any measurement start clears the noise flag, a direct start also clears flags 1 to 5
    // overtemp flag also cleared at start
    if (meas_evt.start)
    begin
      s_next.in_meas = 1'b1;
      s_next.direct = meas_evt.direct;
      s_next.ov_pre = meas_evt.ov;
      s_next.tx_stop = 1'b0;
      s_next.ring_on = 1'b0;
      s_next.tout_run = 1'b0;
      s_next.decayed_early = 1'b0;
      s_next.flags[FLAG_NOISE] = 1'b0;
      s_next.flags[FLAG_OVERTEMP] = 1'b0;
      if (meas_evt.direct)
        s_next.flags[FLAG_RING_TOUT:FLAG_SUPPLY] = '0;
    end
    else if (s_reg.in_meas)
    begin
      if (meas_evt.noise_over)
        s_next.flags[FLAG_NOISE] = 1'b1;
      if (s_reg.direct && meas_evt.tx_active)
      begin
        // ov crossing only counts if not high before tx
        if (meas_evt.uv || (meas_evt.ov && !s_reg.ov_pre))
          s_next.flags[FLAG_SUPPLY] = 1'b1;
        if (meas_evt.ov)
          s_next.tx_stop = 1'b1;
      end
      // ringing evaluation only in direct mode
      if (s_reg.direct && meas_evt.tx_end)
      begin
        s_next.tout_run = 1'b1;
        s_next.ring_on = 1'b1;
        // largest code times the step needs seventeen bits
        s_next.tout_cnt = 17'({9'h000, ring_cfg.ringing_end_timeout} * RING_TOUT_STEP_OSC);
        s_next.mon_cnt = {8'h00, ring_cfg.ringing_monitor_window};
      end
      if (s_reg.tout_run && s_reg.tick)
      begin
        if (s_reg.mon_cnt != 16'h0000)
          s_next.mon_cnt = s_reg.mon_cnt - 16'h0001;
        if (s_reg.tout_cnt != 17'h00000)
          s_next.tout_cnt = s_reg.tout_cnt - 17'h00001;
      end
      if (s_reg.tout_run && s_reg.ring_on && meas_evt.ring_decayed)
      begin
        s_next.ring_on = 1'b0;
        if (s_reg.mon_cnt != 16'h0000)
          s_next.flags[FLAG_SHORT_DECAY] = 1'b1;
      end
      if (s_reg.tout_run && s_reg.tout_cnt == 17'h00000)
      begin
        s_next.tout_run = 1'b0;
        if (s_reg.ring_on && meas_evt.ring_present)
          s_next.flags[FLAG_RING_TOUT] = 1'b1;
      end
      if (meas_evt.done)
      begin
        s_next.in_meas = 1'b0;
        s_next.tout_run = 1'b0;
        if (s_reg.direct)
        begin
          if ((ring_cfg.measured_ringing_period >
               ring_cfg.carrier_period + ring_cfg.ringing_period_tolerance) ||
              (ring_cfg.measured_ringing_period + ring_cfg.ringing_period_tolerance <
               ring_cfg.carrier_period))
            s_next.flags[FLAG_PER_UPD] = 1'b1;
          s_next.flags[FLAG_PER_DIR] =
            ring_cfg.measured_ringing_period > ring_cfg.carrier_period;
        end
      end
    end

    // read of item 1 clears clear-on-read flag
    if (flag_read)
      s_next.por_flag = 1'b0;

    // thermal event sets flag, set wins over clear
    if (s_reg.ot_state)
      s_next.flags[FLAG_OVERTEMP] = 1'b1;

    // eeprom sequencer
    unique case (s_reg.st)
      RF_IDLE:
      begin
        if (s_reg.boot || refresh_cmd)
        begin
          s_next.boot = 1'b0;
          s_next.st = RF_READ;
          s_next.addr = '0;
          s_next.crc = CRC_INIT;
          s_next.dbl_acc = 1'b0;
        end
        else if (program_cmd)
        begin
          s_next.st = PG_WRITE;
          s_next.addr = '0;
          s_next.crc = CRC_INIT;
        end
      end
      RF_READ:
        s_next.st = RF_WAIT;
      RF_WAIT:
      begin
        if (ee_rvalid)
        begin
          s_next.dbl_acc = s_reg.dbl_acc | dec[8];
          if (s_reg.addr == (ADDR_W + 1)'(CFG_WORDS))
          begin
            // stored crc word compared while its data stands
            s_next.crc_err = (dec[7:0] != s_reg.crc);
            s_next.st = RF_CHECK;
          end
          else
          begin
            s_next.crc = crc_step(s_reg.crc, dec[7:0]);
            s_next.addr = s_reg.addr + 1'b1;
            s_next.st = RF_READ;
          end
        end
      end
      RF_CHECK:
      begin
        s_next.dbl_err = s_reg.dbl_acc;
        s_next.st = RF_IDLE;
      end
      PG_WRITE:
      begin
        s_next.crc = crc_step(s_reg.crc, cfg_mem[s_reg.addr[ADDR_W-1:0]]);
        if (last_word)
          s_next.st = PG_CRC;
        s_next.addr = s_reg.addr + 1'b1;
      end
      PG_CRC:
        s_next.st = RF_IDLE;
      default:
        s_next.st = RF_IDLE;
    endcase

    s_next.flags[FLAG_HW_ERR] = s_next.por_flag | s_next.dbl_err | s_next.crc_err;
    s_next.rd_data = (cfg_rd_addr == ADDR_W'(CFG_ITEM_STATUS)) ? s_reg.flags :
                     cfg_mem[cfg_rd_addr];
  end

  // ==========================================================
  // registers
  // period update flag preset at power-on
  // flags change only through the events above
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_reg <= '0;
      s_reg.flags <= FLAGS_RESET;
      s_reg.por_flag <= 1'b1;
      s_reg.boot <= 1'b1;
      s_reg.st <= RF_IDLE;
    end
    else if (clk_en)
      s_reg <= s_next;
  end

  // ==========================================================
  // configuration memory
  // refresh loads backed cells
  // unbacked cells get the default once
  always_ff @(posedge clk_sys)
  begin
    if (clk_en)
    begin
      for (int i = 0; i < CFG_WORDS; i++)
      begin
        if (s_reg.boot && !cfg_backed[i])
          cfg_mem[i] <= DEFAULT_CELL;
      end
      if (s_reg.st == RF_WAIT && ee_rvalid && s_reg.addr != (ADDR_W + 1)'(CFG_WORDS) &&
          cfg_backed[s_reg.addr[ADDR_W-1:0]])
        cfg_mem[s_reg.addr[ADDR_W-1:0]] <= dec[7:0];
    end
  end

  // ==========================================================
  // outputs
  assign sensor_condition_flags = s_reg.flags;
  assign cfg_rd_data = s_reg.rd_data;
  assign line_echo = s_reg.echo;
  assign power_down = s_reg.pd;
  assign tx_stop = s_reg.tx_stop;
  assign osc_tick = s_reg.tick;
  assign ee_rd_req = (s_reg.st == RF_READ);
  assign ee_wr_req = (s_reg.st == PG_WRITE) || (s_reg.st == PG_CRC);
  assign ee_addr = s_reg.addr;
  // stored crc word is ecc protected too
  assign ee_wdata = (s_reg.st == PG_CRC) ? ecc_encode(s_reg.crc) :
                    ecc_encode(cfg_mem[s_reg.addr[ADDR_W-1:0]]);
  assign refresh_busy = (s_reg.st != RF_IDLE);

endmodule

/* core/sensor_flags_pkg.sv */
// shared constants and carrier types for the sensor_condition_flags flag block
package sensor_flags_pkg;

  // ==========================================================
  // timing
  localparam int OSC_PERIOD_NS = 100;
  localparam int SYS_PERIOD_NS = 4;
  localparam int OSC_DIV = OSC_PERIOD_NS / SYS_PERIOD_NS;
  localparam real RING_TOUT_STEP_US = 51.2;
  localparam int RING_TOUT_STEP_OSC = int'(RING_TOUT_STEP_US * 1000.0) / OSC_PERIOD_NS;

  // ==========================================================
  // flag positions
  localparam int FLAG_NOISE = 0;
  localparam int FLAG_SUPPLY = 1;
  localparam int FLAG_PER_UPD = 2;
  localparam int FLAG_PER_DIR = 3;
  localparam int FLAG_SHORT_DECAY = 4;
  localparam int FLAG_RING_TOUT = 5;
  localparam int FLAG_OVERTEMP = 6;
  localparam int FLAG_HW_ERR = 7;
  localparam logic [7:0] FLAGS_RESET = 8'h84;

  // ==========================================================
  // crc and eeprom word layout
  localparam logic [7:0] CRC_POLY = 8'h2F;
  localparam logic [7:0] CRC_INIT = 8'hFF;
  localparam int EE_DATA_W = 8;
  localparam int EE_ECC_W = 5;
  localparam int EE_WORD_W = EE_DATA_W + EE_ECC_W;
  localparam logic [7:0] CFG_ITEM_STATUS = 8'h01;
  localparam logic [7:0] DEFAULT_CELL = 8'h00;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic start;
    logic direct;
    logic done;
    logic tx_active;
    logic tx_end;
    logic noise_over;
    logic ring_present;
    logic ring_decayed;
    logic uv;
    logic ov;
  } meas_evt_t;

  typedef struct packed {
    logic [9:0] measured_ringing_period;
    logic [9:0] carrier_period;
    logic [9:0] ringing_period_tolerance;
    logic [7:0] ringing_monitor_window;
    logic [7:0] ringing_end_timeout;
  } ring_cfg_t;

  typedef enum logic [2:0] {
    RF_IDLE,
    RF_READ,
    RF_WAIT,
    RF_CHECK,
    PG_WRITE,
    PG_CRC
  } ee_state_t;

endpackage
